// ---- src/mwm_pkg.sv ----
package mwm_pkg;

  // ****************************************************************
  // Pin and bus sizes
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int IDX_W = 6;
  localparam int BLOCK_ADDR_W = 28;
  localparam int BLOCK_HI_W = 12;

  // ****************************************************************
  // Word indices (host_address_lines[6:1])
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_WIDTH_SEL = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RSVD_LOW = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STATUS_LO = 6'h02;
  localparam logic [IDX_W-1:0] IDX_STATUS_HI = 6'h03;
  localparam logic [IDX_W-1:0] IDX_ERROR_LO = 6'h04;
  localparam logic [IDX_W-1:0] IDX_ERROR_HI = 6'h05;
  localparam logic [IDX_W-1:0] IDX_CFG_ADDR_LO = 6'h06;
  localparam logic [IDX_W-1:0] IDX_CFG_ADDR_HI = 6'h07;
  localparam logic [IDX_W-1:0] IDX_HOST_ADDR_LO = 6'h08;
  localparam logic [IDX_W-1:0] IDX_HOST_ADDR_HI = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SECTOR_CMD = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_REVISION = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_CONTROL_LO = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_CONTROL_HI = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_FILE_TABLE = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_RSVD_LAST = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_BUF_FIRST = 6'h20;

  // ****************************************************************
  // Reset values and status fields
  // ****************************************************************
  localparam logic RST_WIDTH_SEL = 1'b0;
  localparam logic [BLOCK_ADDR_W-1:0] RST_HOST_BLOCK_ADDR = 28'h0000000;
  localparam logic [15:0] RST_SECTOR_CMD = 16'h0000;
  localparam logic [31:0] RST_CONTROL = 32'h00000000;
  localparam int STAT_BUF_RDY_BIT = 5;
  localparam int STAT_BUF_MODE_BIT = 6;

  // ****************************************************************
  // Data buffer
  // ****************************************************************
  localparam int BUF_DEPTH = 16;
  localparam int BUF_PTR_W = 4;
  localparam int BUF_CNT_W = 5;
  localparam logic [BUF_CNT_W-1:0] BUF_FULL_CNT = 5'h10;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic cs_n;
    logic oe_n;
    logic we_n;
  } mwm_pins_t;

  localparam mwm_pins_t PINS_IDLE = '{addr: 7'h00, data: 16'h0000,
                                      cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage

// ---- src/mwm_host_port.sv ----
`timescale 1ns/10ps
// Behaviour
// RULE1 - Width bit 1: word mode, all sixteen data lines, address bits 6:1.
// RULE2 - Width bit 0: byte mode, all address bits, data lines 7:0 only.
// RULE3 - Width bit resets to 0, so the port starts in byte mode.
// RULE4 - Width register aliased at byte 0x00, 0x01 and word 0x0.
// RULE5 - Status word read as halves at word 0x02 and 0x03; read-only.
// RULE6 - Error word read as halves at word 0x04 and 0x05.
// RULE7 - Configuration block address read at 0x06 (15:0) and 0x07 (27:16).
// RULE8 - Host block address read/write at 0x08 (15:0) and 0x09 (27:16).
// RULE9 - Sector count and card command register, read/write, at word 0x0A.
// RULE10 - Control word read/write as halves at word 0x0C and 0x0D.
// RULE11 - File table information read-only at word 0x0E.
// RULE12 - Word addresses 0x20 through 0x3F reach the data buffer both ways.
// RULE13 - Data buffer holds sixteen entries of sixteen bits.
// RULE14 - Reserved addresses 0x01, 0x0F-0x1F read zero, ignore writes.
// RULE15 - Host sets width first, then uses matching lanes and addresses.
module mwm_host_port
  import mwm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Host pins
  input wire logic [ADDR_W-1:0] i_host_addr,
  input wire logic [DATA_W-1:0] i_host_data,
  input wire logic i_host_cs_n,
  input wire logic i_host_oe_n,
  input wire logic i_host_we_n,
  output logic [DATA_W-1:0] o_host_data,
  output logic [1:0] o_host_data_oe,
  // Controller core state
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_error_word,
  input wire logic [BLOCK_ADDR_W-1:0] i_config_block_addr,
  input wire logic [15:0] i_revision_info,
  input wire logic [15:0] i_file_table_info,
  // Controller core buffer side
  input wire logic i_core_push,
  input wire logic [DATA_W-1:0] i_core_data,
  input wire logic i_core_pop,
  output logic [DATA_W-1:0] o_core_data,
  output logic o_core_valid,
  output logic o_core_space,
  // Host-programmed settings and buffer ready flag
  output logic o_bus_width,
  output logic o_buf_ready,
  output logic [BLOCK_ADDR_W-1:0] o_host_block_addr,
  output logic [15:0] o_sector_count_command,
  output logic [31:0] o_controller_control_word
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic is_buf(input logic [IDX_W-1:0] idx);
    is_buf = (idx >= IDX_BUF_FIRST);
  endfunction

  function automatic logic is_rsvd(input logic [IDX_W-1:0] idx);
    is_rsvd = (idx == IDX_RSVD_LOW) ||
              ((idx >= IDX_RSVD_FIRST) && (idx <= IDX_RSVD_LAST));
  endfunction

  // Byte mode touches one lane and keeps the other
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] d,
                                          input logic wide,
                                          input logic hi);
    merge16 = wide ? d : (hi ? {d[7:0], old[7:0]} : {old[15:8], d[7:0]});
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  mwm_pins_t pin_s1_ff;
  mwm_pins_t pin_s2_ff;
  mwm_pins_t pin_now;

  assign pin_now = '{addr: i_host_addr, data: i_host_data,
                     cs_n: i_host_cs_n, oe_n: i_host_oe_n,
                     we_n: i_host_we_n};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_ff <= PINS_IDLE;
      pin_s2_ff <= PINS_IDLE;
    end else begin
      pin_s1_ff <= pin_now;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ****************************************************************
  // Access strobes
  // ****************************************************************
  logic wr_act;
  logic rd_act;
  logic wr_prev_ff;
  logic rd_prev_ff;
  logic wr_stb;
  logic rd_stb;
  logic [IDX_W-1:0] idx;
  logic lane_hi;
  logic [15:0] wdata;
  logic width_ff;
  logic wide;

  assign wr_act = !pin_s2_ff.cs_n && !pin_s2_ff.we_n;
  assign rd_act = !pin_s2_ff.cs_n && !pin_s2_ff.oe_n && pin_s2_ff.we_n;
  assign wr_stb = wr_act && !wr_prev_ff;
  assign rd_stb = rd_act && !rd_prev_ff;
  assign wide = width_ff;
  // RULE1 word index
  // Both modes use bits 6:1 as index; bit 0 picks the lane in byte mode
  assign idx = pin_s2_ff.addr[ADDR_W-1:1];
  // RULE4 lane alias
  // Width register has one bit, so byte 0x01 aliases to its low lane
  assign lane_hi = !wide && pin_s2_ff.addr[0] && (idx != IDX_WIDTH_SEL);
  assign wdata = pin_s2_ff.data;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
    end else begin
      wr_prev_ff <= wr_act;
      rd_prev_ff <= rd_act;
    end
  end

  // ****************************************************************
  // Host registers
  // ****************************************************************
  logic [15:0] host_addr_lo_ff;
  logic [BLOCK_HI_W-1:0] host_addr_hi_ff;
  logic [15:0] sector_cmd_ff;
  logic [31:0] control_ff;
  logic [15:0] host_hi_merged;

  assign host_hi_merged = merge16({4'h0, host_addr_hi_ff}, wdata, wide,
                                  lane_hi);

  // RULE3 byte mode after reset
  // RULE4 width select write
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      width_ff <= RST_WIDTH_SEL;
    end else if (wr_stb && idx == IDX_WIDTH_SEL) begin
      width_ff <= wdata[0];
    end
  end

  // RULE8 host block address
  // RULE9 sector count command
  // RULE10 control word halves
  // RULE14 reserved writes dropped
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      host_addr_lo_ff <= RST_HOST_BLOCK_ADDR[15:0];
      host_addr_hi_ff <= RST_HOST_BLOCK_ADDR[BLOCK_ADDR_W-1:16];
      sector_cmd_ff <= RST_SECTOR_CMD;
      control_ff <= RST_CONTROL;
    end else if (wr_stb) begin
      case (idx)
        IDX_HOST_ADDR_LO: begin
          host_addr_lo_ff <= merge16(host_addr_lo_ff, wdata, wide, lane_hi);
        end
        IDX_HOST_ADDR_HI: begin
          host_addr_hi_ff <= host_hi_merged[BLOCK_HI_W-1:0];
        end
        IDX_SECTOR_CMD: begin
          sector_cmd_ff <= merge16(sector_cmd_ff, wdata, wide, lane_hi);
        end
        IDX_CONTROL_LO: begin
          control_ff[15:0] <= merge16(control_ff[15:0], wdata, wide,
                                      lane_hi);
        end
        IDX_CONTROL_HI: begin
          control_ff[31:16] <= merge16(control_ff[31:16], wdata, wide,
                                       lane_hi);
        end
        default: begin
          control_ff <= control_ff;
        end
      endcase
    end
  end

  // ****************************************************************
  // Data buffer
  // ****************************************************************
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [BUF_PTR_W-1:0] wr_ptr_ff;
  logic [BUF_PTR_W-1:0] rd_ptr_ff;
  logic [BUF_CNT_W-1:0] count_ff;
  logic [7:0] lo_hold_ff;
  logic buf_wmode;
  logic not_full;
  logic not_empty;
  logic word_done;
  logic host_push;
  logic host_pop;
  logic core_push;
  logic core_pop;
  logic push;
  logic pop;
  logic [DATA_W-1:0] push_data;

  assign buf_wmode = i_status_word[STAT_BUF_MODE_BIT];
  assign not_full = (count_ff != BUF_FULL_CNT);
  assign not_empty = (count_ff != '0);
  // Byte mode moves a word on its odd (high) byte only
  assign word_done = wide || pin_s2_ff.addr[0];
  // RULE12 buffer window access
  assign host_push = wr_stb && is_buf(idx) && buf_wmode && word_done &&
                     not_full;
  assign host_pop = rd_stb && is_buf(idx) && !buf_wmode && word_done &&
                    not_empty;
  assign core_push = i_core_push && !buf_wmode && not_full;
  assign core_pop = i_core_pop && buf_wmode && not_empty;
  assign push = host_push || core_push;
  assign pop = host_pop || core_pop;
  assign push_data = buf_wmode ? (wide ? wdata : {wdata[7:0], lo_hold_ff})
                               : i_core_data;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lo_hold_ff <= 8'h00;
    end else if (wr_stb && is_buf(idx) && !wide && !pin_s2_ff.addr[0]) begin
      lo_hold_ff <= wdata[7:0];
    end
  end

  // Storage carries no reset; only pointers define its contents
  always_ff @(posedge i_clk) begin
    if (push) begin
      buf_mem[wr_ptr_ff] <= push_data;
    end
  end

  // RULE13 sixteen-entry occupancy
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 4'h1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 4'h1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 5'h01;
      end else if (pop && !push) begin
        count_ff <= count_ff - 5'h01;
      end
    end
  end

  // Head view lags a pop by one cycle, so the core pops every other cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_data <= 16'h0000;
      o_core_valid <= 1'b0;
      o_core_space <= 1'b0;
      o_buf_ready <= 1'b0;
    end else begin
      o_core_data <= buf_mem[rd_ptr_ff];
      o_core_valid <= buf_wmode && not_empty && !pop;
      o_core_space <= !buf_wmode && not_full && !push;
      o_buf_ready <= buf_wmode ? not_full : not_empty;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] status_view;
  logic [15:0] rd_word;
  logic [15:0] rd_pins;

  always_comb begin
    status_view = i_status_word;
    status_view[STAT_BUF_RDY_BIT] = o_buf_ready;
  end

  // RULE5 status halves
  // RULE6 error halves
  // RULE7 configuration address
  // RULE11 file table info
  // RULE14 reserved reads zero
  always_comb begin
    rd_word = 16'h0000;
    if (is_buf(idx)) begin
      rd_word = buf_mem[rd_ptr_ff];
    end else begin
      case (idx)
        IDX_WIDTH_SEL: rd_word = {15'h0000, width_ff};
        IDX_STATUS_LO: rd_word = status_view[15:0];
        IDX_STATUS_HI: rd_word = status_view[31:16];
        IDX_ERROR_LO: rd_word = i_error_word[15:0];
        IDX_ERROR_HI: rd_word = i_error_word[31:16];
        IDX_CFG_ADDR_LO: rd_word = i_config_block_addr[15:0];
        IDX_CFG_ADDR_HI: rd_word = {4'h0, i_config_block_addr[27:16]};
        IDX_HOST_ADDR_LO: rd_word = host_addr_lo_ff;
        IDX_HOST_ADDR_HI: rd_word = {4'h0, host_addr_hi_ff};
        IDX_SECTOR_CMD: rd_word = sector_cmd_ff;
        IDX_REVISION: rd_word = i_revision_info;
        IDX_CONTROL_LO: rd_word = control_ff[15:0];
        IDX_CONTROL_HI: rd_word = control_ff[31:16];
        IDX_FILE_TABLE: rd_word = i_file_table_info;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // RULE2 byte lane select
  assign rd_pins = wide ? rd_word
                        : {8'h00, lane_hi ? rd_word[15:8] : rd_word[7:0]};

  // RULE1 word lanes driven
  // RULE2 low lanes only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_host_data <= 16'h0000;
      o_host_data_oe <= 2'b00;
    end else begin
      if (rd_stb) begin
        o_host_data <= rd_pins;
      end
      o_host_data_oe <= rd_act ? (wide ? 2'b11 : 2'b01) : 2'b00;
    end
  end

  assign o_bus_width = width_ff;
  assign o_host_block_addr = {host_addr_hi_ff, host_addr_lo_ff};
  assign o_sector_count_command = sector_cmd_ff;
  assign o_controller_control_word = control_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  logic seen_width_wr_ff;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_width_wr_ff <= 1'b0;
    end else if (wr_stb && idx == IDX_WIDTH_SEL) begin
      seen_width_wr_ff <= 1'b1;
    end
  end

  chk_width_reset_byte: assert property ( // RULE3
    !seen_width_wr_ff |-> !o_bus_width)
    else $error("width select left byte mode without a write");
  chk_width_alias_only: assert property ( // RULE4
    $changed(o_bus_width) |-> $past(wr_stb && idx == IDX_WIDTH_SEL))
    else $error("width select changed outside its address");
  chk_word_lanes: assert property ( // RULE1
    rd_stb && wide |=> o_host_data_oe == 2'b11)
    else $error("word read did not drive all sixteen lines");
  chk_byte_lanes: assert property ( // RULE2
    rd_stb && !wide |=> o_host_data_oe == 2'b01 && o_host_data[15:8] == 8'h00)
    else $error("byte read drove upper data lines");
  chk_status_high: assert property ( // RULE5
    rd_stb && wide && idx == IDX_STATUS_HI
      |=> o_host_data == $past(status_view[31:16]))
    else $error("status high half read wrong");
  chk_error_low: assert property ( // RULE6
    rd_stb && wide && idx == IDX_ERROR_LO
      |=> o_host_data == $past(i_error_word[15:0]))
    else $error("error low half read wrong");
  chk_cfg_addr_high: assert property ( // RULE7
    rd_stb && wide && idx == IDX_CFG_ADDR_HI
      |=> o_host_data == {4'h0, $past(i_config_block_addr[27:16])})
    else $error("configuration address high read wrong");
  chk_host_addr_write: assert property ( // RULE8
    wr_stb && wide && idx == IDX_HOST_ADDR_HI
      |=> o_host_block_addr[27:16] == $past(wdata[11:0]))
    else $error("host block address high not written");
  chk_control_write: assert property ( // RULE10
    wr_stb && wide && idx == IDX_CONTROL_LO
      |=> o_controller_control_word[15:0] == $past(wdata)
          ##1 $stable(o_controller_control_word[15:0]) || wr_stb)
    else $error("control low half not written");
  chk_reserved_zero: assert property ( // RULE14
    rd_stb && is_rsvd(idx) |=> o_host_data == 16'h0000)
    else $error("reserved address read non-zero");
  chk_buffer_push: assert property ( // RULE12
    wr_stb && wide && is_buf(idx) && buf_wmode && not_full
      |=> count_ff == $past(count_ff) + 5'h01 - {4'h0, $past(core_pop)})
    else $error("buffer window write not stored");
  chk_buffer_depth: assert property ( // RULE13
    count_ff <= BUF_FULL_CNT)
    else $error("buffer occupancy above sixteen");

  cov_word_mode_on: cover property (wr_stb && idx == IDX_WIDTH_SEL
                                    ##1 o_bus_width);
  cov_buffer_full: cover property (count_ff == BUF_FULL_CNT);
  cov_byte_pair_push: cover property (host_push && !wide);

endmodule

// ---- sim/mwm_host_model.sv ----
`timescale 1ns/10ps
module mwm_host_model
  import mwm_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Device side of the host pins
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [1:0] i_data_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_data,
  output logic o_cs_n,
  output logic o_oe_n,
  output logic o_we_n
);
  logic drive;
  logic [DATA_W-1:0] hold;

  // Lanes nobody drives show the inverse, so a stale value never matches
  assign o_data = drive ? hold :
    {i_data_oe[1] ? i_data[15:8] : ~hold[15:8],
     i_data_oe[0] ? i_data[7:0] : ~hold[7:0]};

  initial begin
    drive = 1'b0;
    hold = 16'h0000;
    o_addr = 7'h00;
    o_cs_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
  end

  // ****************************************************************
  // One host cycle, held well past the synchronised strobe
  // ****************************************************************
  // drives all sixteen lanes whatever the width
  task automatic access(input bit wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q,
                        output logic [1:0] oe);
    int n;
    q = 16'h0000;
    oe = 2'b00;
    @(negedge i_clk);
    o_addr = a;
    hold = d;
    drive = wr;
    o_cs_n = 1'b0;
    o_we_n = !wr;
    o_oe_n = wr;
    for (n = 0; n < 8; n++) begin
      @(negedge i_clk);
      if (!wr && oe === 2'b00 && i_data_oe !== 2'b00) begin
        q = i_data;
        oe = i_data_oe;
      end
    end
    drive = 1'b0;
    o_cs_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule

// ---- sim/test_mwm_host_port.sv ----
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module test_mwm_host_port
  import mwm_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_resetn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hdin, hdout, cdin, cdout, rev, fat, sec, q;
  logic cs_n, oe_n, we_n, push, pop, cvalid, cspace, bw, brdy, wid;
  logic [1:0] hoe, qoe;
  logic [31:0] st, er, ctl;
  logic [27:0] cfg, hba;
  logic [15:0] mir [16];
  logic [15:0] bq [$];
  logic [7:0] blo = 8'h00;
  int n_fail = 0;
  int cmp_count = 0;
  int i;

  always #25 i_clk = ~i_clk;

  mwm_host_port i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_host_addr(addr),
    .i_host_data(hdin), .i_host_cs_n(cs_n), .i_host_oe_n(oe_n),
    .i_host_we_n(we_n), .o_host_data(hdout), .o_host_data_oe(hoe),
    .i_status_word(st), .i_error_word(er), .i_config_block_addr(cfg),
    .i_revision_info(rev), .i_file_table_info(fat), .i_core_push(push),
    .i_core_data(cdin), .i_core_pop(pop), .o_core_data(cdout),
    .o_core_valid(cvalid), .o_core_space(cspace), .o_bus_width(bw),
    .o_buf_ready(brdy), .o_host_block_addr(hba),
    .o_sector_count_command(sec), .o_controller_control_word(ctl));

  mwm_host_model i_host (
    .i_clk(i_clk), .i_data(hdout), .i_data_oe(hoe), .o_addr(addr),
    .o_data(hdin), .o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Reference model of the register map
  // ****************************************************************
  function automatic logic rdy();
    return st[6] ? bq.size() < BUF_DEPTH : bq.size() > 0;
  endfunction

  function automatic logic [15:0] ew(logic [5:0] x);
    logic [15:0] w;
    case (x)
      6'h00: w = {15'h0000, wid};
      6'h02: w = {st[15:6], rdy(), st[4:0]};
      6'h03: w = st[31:16];
      6'h04: w = er[15:0];
      6'h05: w = er[31:16];
      6'h06: w = cfg[15:0];
      6'h07: w = {4'h0, cfg[27:16]};
      6'h09: w = {4'h0, mir[9][11:0]};
      6'h08, 6'h0a, 6'h0c, 6'h0d: w = mir[x[3:0]];
      6'h0b: w = rev;
      6'h0e: w = fat;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic logic [15:0] eb(logic [6:0] a);
    logic [15:0] w;
    w = ew(a[6:1]);
    if (a[6:1] == 6'h00)
      return w;
    return a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  task automatic rd(logic [6:0] a, logic [15:0] e);
    i_host.access(1'b0, a, 16'h0000, q, qoe);
    `CHK(q, e);
    `CHK(qoe, wid ? 2'b11 : 2'b01);
  endtask

  task automatic wr(logic [6:0] a, logic [15:0] d);
    logic [5:0] x;
    x = a[6:1];
    i_host.access(1'b1, a, d, q, qoe);
    if (x == 6'h00)
      wid = d[0];
    else if (x inside {6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0d}) begin
      if (wid)
        mir[x[3:0]] = d;
      else if (a[0])
        mir[x[3:0]][15:8] = d[7:0];
      else
        mir[x[3:0]][7:0] = d[7:0];
    end else if (x >= IDX_BUF_FIRST && !wid && !a[0])
      blo = d[7:0];
    else if (x >= IDX_BUF_FIRST && st[6] && bq.size() < BUF_DEPTH)
      bq.push_back(wid ? d : {d[7:0], blo});
  endtask

  task automatic chk_out();
    `CHK(bw, wid);
    `CHK(hba, {mir[9][11:0], mir[8]});
    `CHK(sec, mir[10]);
    `CHK(ctl, {mir[13], mir[12]});
  endtask

  task automatic core_pop();
    int n;
    for (n = 0; n < 20 && cvalid !== 1'b1; n++)
      @(negedge i_clk);
    `CHK(cdout, bq.pop_front());
    pop = 1'b1;
    @(negedge i_clk);
    pop = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  task automatic core_push(logic [15:0] d);
    int n;
    for (n = 0; n < 20 && cspace !== 1'b1; n++)
      @(negedge i_clk);
    cdin = d;
    push = 1'b1;
    bq.push_back(d);
    @(negedge i_clk);
    push = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    i_resetn = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    cdin = 16'h0000;
    void'($urandom(32'hb151d080));
    st = $urandom();
    er = $urandom();
    cfg = 28'($urandom());
    rev = 16'($urandom());
    fat = 16'($urandom());
    st[6] = 1'b0;
    wid = 1'b0;
    for (i = 0; i < 16; i++)
      mir[i] = 16'h0000;
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    chk_out();
    for (i = 0; i < 64; i++)
      rd(7'(i), eb(7'(i)));
    // Upper data lanes carry noise that byte mode must ignore
    for (i = 16; i < 28; i++)
      wr(7'(i), 16'($urandom()));
    chk_out();
    for (i = 16; i < 28; i++)
      rd(7'(i), eb(7'(i)));
    wr(7'h01, 16'hff01);
    `CHK(bw, 1'b1);
    for (i = 1; i < 32; i++)
      wr(7'(i * 2), 16'($urandom()));
    chk_out();
    // Odd addresses show that bit 0 is ignored in word mode
    for (i = 0; i < 32; i++)
      rd(7'(i * 2 + i % 2), ew(6'(i)));
    wr(7'h00, 16'hfffe);
    `CHK(bw, 1'b0);
    wr(7'h00, 16'h0001);
    rd(7'h00, 16'h0001);
    st[6] = 1'b1;
    for (i = 0; i < 17; i++) begin
      wr(7'($urandom_range(32, 63) * 2), 16'($urandom()));
      `CHK(brdy, bq.size() < BUF_DEPTH);
    end
    rd(7'h04, ew(6'h02));
    while (bq.size() > 0)
      core_pop();
    `CHK(cvalid, 1'b0);
    st[6] = 1'b0;
    for (i = 0; i < 16; i++)
      core_push(16'($urandom()));
    `CHK(cspace, 1'b0);
    `CHK(brdy, 1'b1);
    while (bq.size() > 0) begin
      rd(7'($urandom_range(32, 63) * 2), bq[0]);
      void'(bq.pop_front());
      `CHK(brdy, bq.size() > 0);
    end
    // Mid-run reset falls back to byte mode with cleared registers
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    wid = 1'b0;
    for (i = 0; i < 16; i++)
      mir[i] = 16'h0000;
    chk_out();
    // Byte mode buffer: even byte is held, odd byte completes the word
    st[6] = 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(7'($urandom_range(32, 63) * 2), 16'($urandom()));
      wr(7'($urandom_range(32, 63) * 2 + 1), 16'($urandom()));
    end
    while (bq.size() > 0)
      core_pop();
    st[6] = 1'b0;
    for (i = 0; i < 4; i++)
      core_push(16'($urandom()));
    while (bq.size() > 0) begin
      rd(7'($urandom_range(32, 63) * 2), {8'h00, bq[0][7:0]});
      rd(7'($urandom_range(32, 63) * 2 + 1), {8'h00, bq[0][15:8]});
      void'(bq.pop_front());
    end
    `CHK(brdy, 1'b0);
    end_of_test();
  end

  // A full run needs about 3000 cycles
  initial begin
    repeat (10000) @(posedge i_clk);
    n_fail++;
    end_of_test();
  end
endmodule
